//--- rtl/catbi_pkg.sv
// constants, field layouts and types of the counter array timebase block
package catbi_pkg;

    // ************************************************************
    // register offsets (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] OFS_CNT_LO   = 8'h00;
    localparam logic [7:0] OFS_CNT_HI   = 8'h04;
    localparam logic [7:0] OFS_MODE     = 8'h08;
    localparam logic [7:0] OFS_IRQ_CTL  = 8'h0C;
    localparam logic [7:0] OFS_MOD_FLAG = 8'h10;
    localparam logic [7:0] OFS_MOD_EN   = 8'h14;
    localparam logic [7:0] OFS_IO_EN    = 8'h18;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int MODE_ECF   = 0;
    localparam int MODE_TBS_L = 1;
    localparam int MODE_TBS_H = 3;
    localparam int MODE_WDT   = 6;
    localparam int MODE_IDLE  = 7;
    localparam int MODE_COF   = 8;
    localparam int IRQ_MIDF   = 0;
    localparam int IRQ_MIDEN  = 1;
    localparam int IRQ_SEL_L  = 2;
    localparam int IRQ_SEL_H  = 3;
    localparam int IRQ_AIE    = 4;
    localparam int IRQ_GIE    = 5;
    localparam int IRQ_PEND   = 6;
    localparam int NUM_MOD    = 6;

    // ************************************************************
    // timebase codes and prescaler limits
    // ************************************************************
    localparam logic [2:0] TB_DIV12  = 3'h0;
    localparam logic [2:0] TB_DIV4   = 3'h1;
    localparam logic [2:0] TB_T0OVF  = 3'h2;
    localparam logic [2:0] TB_EXTIN  = 3'h3;
    localparam logic [2:0] TB_SYSCLK = 3'h4;
    localparam logic [2:0] TB_OSC8   = 3'h5;
    localparam logic [3:0] DIV12_LAST = 4'hB;
    localparam logic [1:0] DIV4_LAST  = 2'h3;
    localparam logic [15:0] CNT_MAX   = 16'hFFFF;
    localparam logic [15:0] CNT_ONE   = 16'h0001;

    // ************************************************************
    // mode register fields and reset value
    // ************************************************************
    typedef struct packed {
        logic       ovf_flag;
        logic       idle_suspend;
        logic       watchdog_en;
        logic [2:0] timebase_select;
        logic       ovf_irq_en;
    } catbi_mode_t;

    localparam catbi_mode_t MODE_RST = '{
        ovf_flag: 1'b0, idle_suspend: 1'b0, watchdog_en: 1'b1,
        timebase_select: TB_DIV12, ovf_irq_en: 1'b0};

endpackage

//--- rtl/catbi_counter_array.sv
// shared counter, timebase selection and interrupt tree of the array
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
module catbi_counter_array (
    // clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_nrst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // count sources
    input  wire logic        i_timer0_overflow,
    input  wire logic        i_external_count_input,
    input  wire logic        i_ext_osc_div8,
    // processor state
    input  wire logic        i_cpu_idle,
    // capture/compare modules
    input  wire logic [5:0]  i_module_trigger,
    input  wire logic [5:0]  i_module_out,
    output logic      [5:0]  o_module_io_line,
    output logic      [5:0]  o_module_io_oe,
    // interrupt and watchdog
    output logic             o_array_irq_request,
    output logic             o_cpu_irq,
    output logic             o_watchdog_enable
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic                 apb_setup;
    logic                 apb_access;
    logic                 apb_wr;
    logic                 apb_rd_setup;
    logic                 hit_lo;
    logic                 hit_hi;
    logic                 hit_mode;
    logic                 hit_irq;
    logic                 hit_flag;
    logic                 hit_men;
    logic                 hit_io;
    logic                 mapped;
    logic [31:0]          next_prdata;
    catbi_pkg::catbi_mode_t mode;
    logic [15:0]          count;
    logic [7:0]           snapshot;
    logic [3:0]           div12;
    logic [1:0]           div4;
    logic                 ext_prev;
    logic                 osc_meta;
    logic                 osc_sync;
    logic                 osc_prev;
    logic                 tick;
    logic                 run;
    logic                 adv;
    logic                 cnt_wr;
    logic                 wrap;
    logic [15:0]          mid_mask;
    logic                 mid_ovf;
    logic                 mid_flag;
    logic                 mid_en;
    logic [1:0]           mid_sel;
    logic                 array_ie;
    logic                 global_ie;
    logic [5:0]           mod_flag;
    logic [5:0]           mod_en;
    logic [5:0]           io_en;
    logic [5:0]           io_line;
    logic                 irq_req;

    // ************************************************************
    // apb decode
    // ************************************************************

    // phases of the transfer
    assign apb_setup    = i_psel & ~i_penable;
    assign apb_access   = i_psel & i_penable;
    assign apb_wr       = apb_access & i_pwrite;
    assign apb_rd_setup = apb_setup & ~i_pwrite;

    // address match per register
    assign hit_lo   = (i_paddr == catbi_pkg::OFS_CNT_LO);
    assign hit_hi   = (i_paddr == catbi_pkg::OFS_CNT_HI);
    assign hit_mode = (i_paddr == catbi_pkg::OFS_MODE);
    assign hit_irq  = (i_paddr == catbi_pkg::OFS_IRQ_CTL);
    assign hit_flag = (i_paddr == catbi_pkg::OFS_MOD_FLAG);
    assign hit_men  = (i_paddr == catbi_pkg::OFS_MOD_EN);
    assign hit_io   = (i_paddr == catbi_pkg::OFS_IO_EN);
    assign mapped   = hit_lo | hit_hi | hit_mode | hit_irq
                    | hit_flag | hit_men | hit_io;

    // zero wait states; unmapped addresses answer with an error
    assign o_pready  = apb_access;
    assign o_pslverr = apb_access & ~mapped;

    // read data mux, sampled during the setup cycle
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (hit_lo) begin
            next_prdata[7:0] = count[7:0];
        end else if (hit_hi) begin
            next_prdata[7:0] = snapshot;
        end else if (hit_mode) begin
            next_prdata[catbi_pkg::MODE_COF:0] = {mode.ovf_flag,
                mode.idle_suspend, mode.watchdog_en, 2'h0,
                mode.timebase_select, mode.ovf_irq_en};
        end else if (hit_irq) begin
            next_prdata[catbi_pkg::IRQ_MIDF]  = mid_flag;
            next_prdata[catbi_pkg::IRQ_MIDEN] = mid_en;
            next_prdata[catbi_pkg::IRQ_SEL_H:catbi_pkg::IRQ_SEL_L] =
                mid_sel;
            next_prdata[catbi_pkg::IRQ_AIE]   = array_ie;
            next_prdata[catbi_pkg::IRQ_GIE]   = global_ie;
            next_prdata[catbi_pkg::IRQ_PEND]  = irq_req;
        end else if (hit_flag) begin
            next_prdata[5:0] = mod_flag;
        end else if (hit_men) begin
            next_prdata[5:0] = mod_en;
        end else if (hit_io) begin
            next_prdata[5:0] = io_en;
        end
    end

    // read data register, ready when the access phase starts
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            o_prdata <= 32'h0000_0000;
        end else if (apb_rd_setup) begin
            o_prdata <= next_prdata;
        end
    end

    // snapshot is taken in the same cycle as the low byte value,
    // so both halves come from one count sample
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            snapshot <= 8'h00;
        end else if (apb_rd_setup && hit_lo) begin
            snapshot <= count[15:8];
        end
    end

    // ************************************************************
    // timebase
    // ************************************************************

    // divide by twelve prescaler
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            div12 <= 4'h0;
        end else if (div12 == catbi_pkg::DIV12_LAST) begin
            div12 <= 4'h0;
        end else begin
            div12 <= div12 + 4'h1;
        end
    end

    // divide by four prescaler
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            div4 <= 2'h0;
        end else begin
            div4 <= div4 + 2'h1; // wraps at three by width
        end
    end

    // external input edge history; input is already synchronous
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= i_external_count_input;
        end
    end

    // two stage resync
    // the oscillator runs apart from the core clock, so only the
    // second stage and later ones are looked at
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= i_ext_osc_div8;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    always_comb begin
        case (mode.timebase_select)
            catbi_pkg::TB_DIV12: begin
                tick = (div12 == catbi_pkg::DIV12_LAST);
            end
            catbi_pkg::TB_DIV4: begin
                tick = (div4 == catbi_pkg::DIV4_LAST);
            end
            catbi_pkg::TB_T0OVF: begin
                tick = i_timer0_overflow;
            end
            catbi_pkg::TB_EXTIN: begin
                tick = ext_prev & ~i_external_count_input;
            end
            catbi_pkg::TB_SYSCLK: begin
                tick = 1'b1;
            end
            catbi_pkg::TB_OSC8: begin
                tick = osc_sync & ~osc_prev;
            end
            default: begin
                tick = 1'b0; // reserved codes stop the counter
            end
        endcase
    end

    assign run = ~(mode.idle_suspend & i_cpu_idle);
    assign adv = tick & run;

    // ************************************************************
    // counter
    // ************************************************************

    assign cnt_wr = apb_wr & (hit_lo | hit_hi) & ~mode.watchdog_en;

    assign wrap = adv & ~cnt_wr & (count == catbi_pkg::CNT_MAX);

    always_comb begin
        case (mid_sel)
            2'h0:    mid_mask = 16'h00FF;
            2'h1:    mid_mask = 16'h01FF;
            2'h2:    mid_mask = 16'h03FF;
            2'h3:    mid_mask = 16'h07FF;
            default: mid_mask = 16'h00FF;
        endcase
    end
    assign mid_ovf = adv & ~cnt_wr & ((count & mid_mask) == mid_mask);

    // reads do not touch it
    // a software write wins over a tick in the same cycle
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            count <= 16'h0000;
        end else if (cnt_wr && hit_lo) begin
            count[7:0] <= i_pwdata[7:0];
        end else if (cnt_wr && hit_hi) begin
            count[15:8] <= i_pwdata[7:0];
        end else if (adv) begin
            count <= count + catbi_pkg::CNT_ONE;
        end
    end

    // ************************************************************
    // mode register
    // ************************************************************

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mode.idle_suspend    <= catbi_pkg::MODE_RST.idle_suspend;
            mode.watchdog_en     <= catbi_pkg::MODE_RST.watchdog_en;
            mode.timebase_select <= catbi_pkg::MODE_RST.timebase_select;
            mode.ovf_irq_en      <= catbi_pkg::MODE_RST.ovf_irq_en;
        end else if (apb_wr && hit_mode) begin
            mode.watchdog_en <= i_pwdata[catbi_pkg::MODE_WDT];
            if (!mode.watchdog_en) begin
                mode.idle_suspend    <= i_pwdata[catbi_pkg::MODE_IDLE];
                mode.timebase_select <= i_pwdata[catbi_pkg::MODE_TBS_H:
                                                 catbi_pkg::MODE_TBS_L];
                mode.ovf_irq_en      <= i_pwdata[catbi_pkg::MODE_ECF];
            end
        end
    end

    // set on wrap
    // write one to clear; a wrap in the same cycle keeps it set
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mode.ovf_flag <= catbi_pkg::MODE_RST.ovf_flag;
        end else if (wrap) begin
            mode.ovf_flag <= 1'b1;
        end else if (apb_wr && hit_mode && i_pwdata[catbi_pkg::MODE_COF]) begin
            mode.ovf_flag <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt control
    // ************************************************************

    // enables and intermediate bit select
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mid_en    <= 1'b0;
            mid_sel   <= 2'h0;
            array_ie  <= 1'b0;
            global_ie <= 1'b0;
        end else if (apb_wr && hit_irq) begin
            mid_en    <= i_pwdata[catbi_pkg::IRQ_MIDEN];
            mid_sel   <= i_pwdata[catbi_pkg::IRQ_SEL_H:
                                  catbi_pkg::IRQ_SEL_L];
            array_ie  <= i_pwdata[catbi_pkg::IRQ_AIE];
            global_ie <= i_pwdata[catbi_pkg::IRQ_GIE];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mid_flag <= 1'b0;
        end else if (mid_ovf) begin
            mid_flag <= 1'b1;
        end else if (apb_wr && hit_irq && i_pwdata[catbi_pkg::IRQ_MIDF]) begin
            mid_flag <= 1'b0;
        end
    end

    // set whatever the enable
    // a trigger beats a clear of the same bit
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mod_flag <= 6'h00;
        end else if (apb_wr && hit_flag) begin
            mod_flag <= (mod_flag & ~i_pwdata[5:0]) | i_module_trigger;
        end else begin
            mod_flag <= mod_flag | i_module_trigger;
        end
    end

    // per module enables
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            mod_en <= 6'h00;
        end else if (apb_wr && hit_men) begin
            mod_en <= i_pwdata[5:0];
        end
    end

    assign irq_req = (mode.ovf_flag & mode.ovf_irq_en)
                   | (mid_flag & mid_en)
                   | (|(mod_flag & mod_en));

    assign o_array_irq_request = irq_req;
    assign o_cpu_irq           = irq_req & global_ie & array_ie;
    assign o_watchdog_enable   = mode.watchdog_en;

    // ************************************************************
    // module io lines
    // ************************************************************

    // io line enable register
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            io_en <= 6'h00;
        end else if (apb_wr && hit_io) begin
            io_en <= i_pwdata[5:0];
        end
    end

    // route only when enabled
    // registered so the pin never sees a glitch from module logic
    always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
            io_line <= 6'h00;
        end else begin
            io_line <= i_module_out & io_en;
        end
    end

    assign o_module_io_line = io_line;
    assign o_module_io_oe   = io_en;

endmodule

//--- tb/catbi_counter_array_properties.sv
// port-level checker of the counter array block
`timescale 1ns/1ps
module catbi_counter_array_properties (
    // clock, reset and apb
    input wire logic        i_core_clk,
    input wire logic        i_nrst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    // module lines, interrupts and watchdog
    input wire logic [5:0]  i_module_out,
    input wire logic [5:0]  o_module_io_line,
    input wire logic [5:0]  o_module_io_oe,
    input wire logic        o_array_irq_request,
    input wire logic        o_cpu_irq,
    input wire logic        o_watchdog_enable
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_nrst);

    // ************************************************************
    // helper logic
    // ************************************************************
    // accepted write and gated module outputs
    logic       wr_acc;
    logic       wr_mode;
    logic [5:0] gated;
    assign wr_acc  = i_psel & i_penable & i_pwrite;
    assign wr_mode = wr_acc & (i_paddr == catbi_pkg::OFS_MODE);
    assign gated   = i_module_out & o_module_io_oe;

    // ************************************************************
    // assertions
    // ************************************************************
    property p_ready;
        i_psel && i_penable |-> o_pready;
    endproperty
    a_ready: assert property (p_ready)
        else $error("access not answered");
    property p_rdata_hold;
        i_psel && i_penable |=> $stable(o_prdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved after access");
    property p_cpu_irq;
        o_cpu_irq |-> o_array_irq_request;
    endproperty
    a_cpu_irq: assert property (p_cpu_irq)
        else $error("cpu interrupt without array request");
    property p_irq_fall;
        $fell(o_array_irq_request) |-> $past(wr_acc);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("request dropped without a write");
    property p_wdt_reset;
        $rose(i_nrst) |-> o_watchdog_enable && !o_array_irq_request;
    endproperty
    a_wdt_reset: assert property (p_wdt_reset)
        else $error("watchdog not on after reset");
    property p_wdt_write;
        wr_mode |=> o_watchdog_enable == $past(i_pwdata[catbi_pkg::MODE_WDT]);
    endproperty
    a_wdt_write: assert property (p_wdt_write)
        else $error("watchdog bit not written");
    property p_wdt_hold;
        !wr_mode |=> $stable(o_watchdog_enable);
    endproperty
    a_wdt_hold: assert property (p_wdt_hold)
        else $error("watchdog bit changed by itself");
    property p_oe_write;
        wr_acc && i_paddr == catbi_pkg::OFS_IO_EN
            |=> o_module_io_oe == $past(i_pwdata[5:0]);
    endproperty
    a_oe_write: assert property (p_oe_write)
        else $error("line enables not written");
    property p_io_line;
        o_pready || !o_pready |=> o_module_io_line == $past(gated);
    endproperty
    a_io_line: assert property (p_io_line)
        else $error("module line not gated by enable");
endmodule

//--- tb/testbench.sv
// self-checking testbench of the counter array block
`timescale 1ns/1ps
module testbench;
    logic        i_core_clk;
    logic        i_nrst;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [7:0]  i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic        i_timer0_overflow;
    logic        i_external_count_input;
    logic        i_ext_osc_div8;
    logic        i_cpu_idle;
    logic [5:0]  i_module_trigger;
    logic [5:0]  i_module_out;
    logic [5:0]  o_module_io_line;
    logic [5:0]  o_module_io_oe;
    logic        o_array_irq_request;
    logic        o_cpu_irq;
    logic        o_watchdog_enable;
    logic [31:0] rd;
    logic [31:0] p;
    logic        err;
    int          n_errors;
    int          checks;

    catbi_counter_array dut (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
        .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_timer0_overflow(i_timer0_overflow),
        .i_external_count_input(i_external_count_input),
        .i_ext_osc_div8(i_ext_osc_div8), .i_cpu_idle(i_cpu_idle),
        .i_module_trigger(i_module_trigger), .i_module_out(i_module_out),
        .o_module_io_line(o_module_io_line),
        .o_module_io_oe(o_module_io_oe),
        .o_array_irq_request(o_array_irq_request),
        .o_cpu_irq(o_cpu_irq), .o_watchdog_enable(o_watchdog_enable));

    // free-running 100 MHz clock
    always #5 i_core_clk = ~i_core_clk;

    // ************************************************************
    // report and compare tasks
    // ************************************************************
    task results;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    // counts whose phase against the prescaler is free get a window
    task chkr(input logic [31:0] got, input int lo, input int hi);
        checks++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h..%h",
                     $time, got, lo, hi);
        end
    endtask

    // ************************************************************
    // apb master: hold request until pready, release after
    // ************************************************************
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        i_psel    <= 1'b1;
        i_pwrite  <= w;
        i_paddr   <= a;
        i_pwdata  <= d;
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        n = 0;
        @(posedge i_core_clk);
        while (o_pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge i_core_clk);
        end
        if (n == 50) begin
            n_errors++;
            results;
        end
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
        #1; // let the edge's updates land before any compare
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdx(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    // clear counter, run one source, stop (reserved code), read low byte
    task tb(input logic [31:0] mode, input int kind,
            input int lo, input int hi);
        wr(catbi_pkg::OFS_CNT_LO, 32'h0);
        wr(catbi_pkg::OFS_CNT_HI, 32'h0);
        wr(catbi_pkg::OFS_MODE, mode);
        for (int i = 0; i < 5; i++) begin
            @(posedge i_core_clk);
            case (kind)
                1: i_timer0_overflow <= 1'b1;
                2: i_external_count_input <= 1'b0;
                3: i_ext_osc_div8 <= 1'b1;
                default: ;
            endcase
            @(posedge i_core_clk);
            i_timer0_overflow <= 1'b0;
            repeat (11) @(posedge i_core_clk);
            i_external_count_input <= 1'b1;
            i_ext_osc_div8 <= 1'b0;
            repeat (11) @(posedge i_core_clk);
        end
        repeat (4) @(posedge i_core_clk); // resync latency of the oscillator
        wr(catbi_pkg::OFS_MODE, 32'h0C);
        apb(1'b0, catbi_pkg::OFS_CNT_LO, 32'h0);
        chkr(rd, lo, hi);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        {i_core_clk, i_psel, i_penable, i_pwrite, i_timer0_overflow} = '0;
        {i_ext_osc_div8, i_cpu_idle, i_nrst} = '0;
        {i_paddr, i_pwdata, i_module_trigger} = '0;
        i_external_count_input = 1'b1;
        i_module_out = 6'h3C;
        repeat (6) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        rdx(catbi_pkg::OFS_MODE, 32'h40);
        chk(o_watchdog_enable, 1'b1);
        rdx(catbi_pkg::OFS_MOD_FLAG, 32'h0);
        wr(catbi_pkg::OFS_CNT_LO, 32'hA5);
        apb(1'b0, catbi_pkg::OFS_CNT_LO, 32'h0);
        chkr(rd, 0, 16);
        wr(catbi_pkg::OFS_MODE, 32'h4C);
        rdx(catbi_pkg::OFS_MODE, 32'h40);
        wr(catbi_pkg::OFS_MODE, 32'h0);
        wr(catbi_pkg::OFS_MODE, 32'h0C);
        rdx(catbi_pkg::OFS_MODE, 32'h0C);
        $display("test reset and lock done");
        // snapshot: live high write must not show before next low read
        wr(catbi_pkg::OFS_CNT_LO, 32'hFF);
        wr(catbi_pkg::OFS_CNT_HI, 32'h12);
        rdx(catbi_pkg::OFS_CNT_LO, 32'hFF);
        wr(catbi_pkg::OFS_CNT_HI, 32'h34);
        rdx(catbi_pkg::OFS_CNT_HI, 32'h12);
        rdx(catbi_pkg::OFS_CNT_LO, 32'hFF);
        rdx(catbi_pkg::OFS_CNT_HI, 32'h34);
        $display("test snapshot done");
        tb(32'h00, 0, 9, 11);
        tb(32'h02, 0, 30, 32);
        tb(32'h08, 0, 124, 128);
        tb(32'h04, 1, 5, 5);
        tb(32'h06, 2, 5, 5);
        tb(32'h0A, 3, 5, 5);
        tb(32'h0E, 0, 0, 0);
        i_cpu_idle <= 1'b1;
        tb(32'h88, 0, 0, 0);
        tb(32'h08, 0, 124, 128);
        i_cpu_idle <= 1'b0;
        wr(catbi_pkg::OFS_MODE, 32'h08);
        apb(1'b0, catbi_pkg::OFS_CNT_LO, 32'h0);
        p = rd;
        apb(1'b0, catbi_pkg::OFS_CNT_LO, 32'h0);
        chk((rd - p) & 32'hFF, 32'h3);
        $display("test timebase done");
        // overflow, its interrupt path and software-only clear
        wr(catbi_pkg::OFS_MODE, 32'h0C);
        wr(catbi_pkg::OFS_CNT_LO, 32'hFF);
        wr(catbi_pkg::OFS_CNT_HI, 32'hFF);
        wr(catbi_pkg::OFS_MODE, 32'h09);
        wr(catbi_pkg::OFS_MODE, 32'h0D);
        rdx(catbi_pkg::OFS_MODE, 32'h10D);
        chk(o_array_irq_request, 1'b1);
        wr(catbi_pkg::OFS_IRQ_CTL, 32'h10);
        chk(o_cpu_irq, 1'b0);
        wr(catbi_pkg::OFS_IRQ_CTL, 32'h30);
        chk(o_cpu_irq, 1'b1);
        repeat (20) @(posedge i_core_clk);
        rdx(catbi_pkg::OFS_MODE, 32'h10D);
        wr(catbi_pkg::OFS_MODE, 32'h10D);
        rdx(catbi_pkg::OFS_MODE, 32'h0D);
        chk(o_array_irq_request, 1'b0);
        $display("test overflow done");
        for (int s = 0; s < 4; s++) begin
            wr(catbi_pkg::OFS_CNT_HI, (32'h1 << s) - 32'h1);
            wr(catbi_pkg::OFS_CNT_LO, 32'hFF);
            wr(catbi_pkg::OFS_IRQ_CTL, (s << 2) | 32'h3);
            apb(1'b0, catbi_pkg::OFS_IRQ_CTL, 32'h0);
            chk(rd & 32'h3F, (s << 2) | 32'h2);
            wr(catbi_pkg::OFS_MODE, 32'h08);
            wr(catbi_pkg::OFS_MODE, 32'h0C);
            apb(1'b0, catbi_pkg::OFS_IRQ_CTL, 32'h0);
            chk(rd & 32'h3F, (s << 2) | 32'h3);
            chk(o_array_irq_request, 1'b1);
        end
        wr(catbi_pkg::OFS_IRQ_CTL, 32'h1);
        $display("test intermediate done");
        // no module runs a short pulse mode here
        for (int k = 0; k < 6; k++) begin
            @(posedge i_core_clk);
            i_module_trigger <= 6'h1 << k;
            @(posedge i_core_clk);
            i_module_trigger <= 6'h0;
            rdx(catbi_pkg::OFS_MOD_FLAG, 32'h1 << k);
            chk(o_array_irq_request, 1'b0);
            wr(catbi_pkg::OFS_MOD_EN, 32'h1 << k);
            chk(o_array_irq_request, 1'b1);
            wr(catbi_pkg::OFS_MOD_FLAG, 32'h1 << k);
            chk(o_array_irq_request, 1'b0);
            wr(catbi_pkg::OFS_MOD_EN, 32'h0);
        end
        $display("test module flags done");
        wr(catbi_pkg::OFS_IO_EN, 32'h15);
        chk(o_module_io_oe, 6'h15);
        @(posedge i_core_clk);
        #1;
        chk(o_module_io_line, 6'h14);
        apb(1'b1, 8'h1C, 32'hFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h1C, 32'h0);
        chk(rd, 32'h0);
        $display("test lines and unmapped done");
        results;
    end
endmodule

bind catbi_counter_array catbi_counter_array_properties u_props (
    .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .i_module_out(i_module_out), .o_module_io_line(o_module_io_line),
    .o_module_io_oe(o_module_io_oe),
    .o_array_irq_request(o_array_irq_request), .o_cpu_irq(o_cpu_irq),
    .o_watchdog_enable(o_watchdog_enable));
